// ===== rtl/ccs_pkg.sv
// constants and types shared by the clock source selection block
package ccs_pkg;

    // ----------------------------------------------------------------
    // source select encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_FAST32 = 3'h0;
    localparam logic [2:0] SRC_SLOW   = 3'h5;
    localparam logic [2:0] SRC_FAST1  = 3'h6;
    localparam logic [2:0] SRC_EXT    = 3'h7;

    // ----------------------------------------------------------------
    // external mode encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] EXT_CLK_HIGH  = 3'h0;
    localparam logic [2:0] EXT_CLK_MED   = 3'h1;
    localparam logic [2:0] EXT_CLK_LOW   = 3'h2;
    localparam logic [2:0] XTAL_LOW_PWR  = 3'h4;
    localparam logic [2:0] XTAL_MED_GAIN = 3'h5;
    localparam logic [2:0] XTAL_HI_GAIN  = 3'h6;

    // ----------------------------------------------------------------
    // amplifier gain and power-range codes
    // ----------------------------------------------------------------
    localparam logic [1:0] GAIN_OFF  = 2'h0;
    localparam logic [1:0] GAIN_LOW  = 2'h1;
    localparam logic [1:0] GAIN_MED  = 2'h2;
    localparam logic [1:0] GAIN_HIGH = 2'h3;

    // power ranges: high 8-32 MHz, medium 0.1-8 MHz, low 0-0.1 MHz
    localparam logic [1:0] PWR_NONE = 2'h0;
    localparam logic [1:0] PWR_LOW  = 2'h1;
    localparam logic [1:0] PWR_MED  = 2'h2;
    localparam logic [1:0] PWR_HIGH = 2'h3;

    // ----------------------------------------------------------------
    // counts and reset values
    // ----------------------------------------------------------------
    localparam int         SUT_CYCLES    = 1024;
    localparam int         FAIL_PERIODS  = 4;
    localparam int         DIV_MAX       = 9;
    localparam logic [3:0] DIV_RESET     = 4'h0;
    localparam int         SLOW_OSC_KHZ  = 31;
    localparam int         FAST_MIN_MHZ  = 1;
    localparam int         FAST_MAX_MHZ  = 16;

    typedef enum logic [2:0]
    {
        ST_START    = 3'h1,
        ST_RUN      = 3'h2,
        ST_FAILSAFE = 3'h4
    } ccs_state_t;

endpackage

// ===== rtl/ccs_fail_monitor.sv
// watchdog on the external clock, paced by slow oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module ccs_fail_monitor #(
    parameter int PERIODS = ccs_pkg::FAIL_PERIODS
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // supervision
    input  wire logic enable,
    input  wire logic slowTick,
    input  wire logic extTick,
    output logic      failPulse
);
    import ccs_pkg::*;

    localparam int CW = $clog2(PERIODS + 1);

    initial
    begin
        if (PERIODS < 2) $error("fail monitor needs at least two periods");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          fail_q;
    logic          fail_d;

    // ----------------------------------------------------------------
    // period counter
    // ----------------------------------------------------------------
    // only slow ticks advance it, so a dead external clock cannot stall it
    always_comb
    begin
        cnt_d  = cnt_q;
        fail_d = 1'b0;
        if (!enable || extTick)
            cnt_d = '0;
        else if (slowTick)
        begin
            if (cnt_q == CW'(PERIODS - 1))
            begin
                fail_d = 1'b1;
                cnt_d  = '0;
            end
            else
                cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_q  <= '0;
            fail_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            fail_q <= fail_d;
        end
    end

    assign failPulse = fail_q;

    a_fail_timing : assert property (@(posedge clock) disable iff (srst)
        (enable && !extTick && slowTick && cnt_q == CW'(PERIODS - 1)) |=> failPulse)
        else $error("missed clock failure");

    a_no_false_fail : assert property (@(posedge clock) disable iff (srst)
        (!enable || extTick) |=> !failPulse)
        else $error("failure flagged while clock alive");

endmodule
`default_nettype wire

// ===== rtl/ccs_source_select.sv
// system clock source selection, start-up timer, divider and fallback
`timescale 1ns/1ps
`default_nettype none
module ccs_source_select #(
    parameter int SUT_COUNT   = ccs_pkg::SUT_CYCLES,
    parameter int FAIL_COUNT  = ccs_pkg::FAIL_PERIODS
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // configuration fields
    input  wire logic [2:0] resetClockSelect,
    input  wire logic [2:0] externalModeSelect,
    // run-time switch request
    input  wire logic       switchWrite,
    input  wire logic [2:0] newSourceRequest,
    input  wire logic [3:0] newDividerRequest,
    // oscillator ticks and events
    input  wire logic       externalClockPin,
    input  wire logic       slowOscTick,
    input  wire logic       fastOscTick,
    input  wire logic       wakeFromSleep,
    input  wire logic       clearClockFail,
    // status and control outputs
    output logic [2:0]      sourceSelect,
    output logic [3:0]      dividerSelect,
    output logic            systemTick,
    output logic [1:0]      amplifierGain,
    output logic [1:0]      extPowerRange,
    output logic            secondPinFree,
    output logic            fast32Select,
    output logic            startupBusy,
    output logic            clockFail
);
    import ccs_pkg::*;

    localparam int OW = $clog2(SUT_COUNT);

    initial
    begin
        if (SUT_COUNT < 2 || (SUT_COUNT & (SUT_COUNT - 1)) != 0)
            $error("start-up count must be a power of two of at least two");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic isCrystal(input logic [2:0] m);
        return m == XTAL_LOW_PWR || m == XTAL_MED_GAIN || m == XTAL_HI_GAIN;
    endfunction

    // unknown codes fall back to the 1 MHz internal source
    function automatic logic [2:0] legalSource(input logic [2:0] s);
        return (s == SRC_FAST32 || s == SRC_SLOW || s == SRC_EXT) ? s : SRC_FAST1;
    endfunction

    // reserved mode codes behave as the high-power logic clock
    function automatic logic [2:0] legalMode(input logic [2:0] m);
        return (isCrystal(m) || m == EXT_CLK_MED || m == EXT_CLK_LOW) ? m : EXT_CLK_HIGH;
    endfunction

    function automatic logic [1:0] gainOf(input logic [2:0] m);
        case (m)
            XTAL_LOW_PWR:  return GAIN_LOW;
            XTAL_MED_GAIN: return GAIN_MED;
            XTAL_HI_GAIN:  return GAIN_HIGH;
            default:       return GAIN_OFF;
        endcase
    endfunction

    function automatic logic [1:0] powerOf(input logic [2:0] m);
        case (m)
            EXT_CLK_HIGH: return PWR_HIGH;
            EXT_CLK_MED:  return PWR_MED;
            EXT_CLK_LOW:  return PWR_LOW;
            default:      return PWR_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ccs_state_t    state_q, state_d;
    logic [2:0]    src_q, src_d;
    logic [2:0]    mode_q, mode_d;
    logic [3:0]    div_q, div_d;
    logic [OW-1:0] sut_q, sut_d;
    logic [8:0]    divCnt_q, divCnt_d;
    logic          tick_q, tick_d;
    logic          fail_q, fail_d;
    logic [1:0]    gain_q, gain_d;
    logic [1:0]    pwr_q, pwr_d;
    logic          pinFree_q, pinFree_d;
    logic          fast32_q, fast32_d;

    logic          failPulse;
    logic          selTick;
    logic          monitorOn;
    logic [8:0]    divMask;
    logic [2:0]    cfgSrc;
    logic [2:0]    cfgMode;

    assign cfgSrc    = legalSource(resetClockSelect);
    assign cfgMode   = legalMode(externalModeSelect);
    assign monitorOn = (src_q == SRC_EXT) && (state_q == ST_RUN)
                       && !switchWrite && !wakeFromSleep;
    assign divMask   = 9'((10'h1 << div_q) - 10'h1);

    ccs_fail_monitor #(
        .PERIODS   (FAIL_COUNT)
    ) u_monitor (
        .clock     (clock),
        .srst      (srst),
        .enable    (monitorOn),
        .slowTick  (slowOscTick),
        .extTick   (externalClockPin),
        .failPulse (failPulse)
    );

    // ----------------------------------------------------------------
    // source tick choice
    // ----------------------------------------------------------------
    always_comb
    begin
        case (src_q)
            SRC_EXT:  selTick = externalClockPin;
            SRC_SLOW: selTick = slowOscTick;
            default:  selTick = fastOscTick;
        endcase
    end

    // ----------------------------------------------------------------
    // selection, start-up and divider next values
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d  = state_q;
        src_d    = src_q;
        mode_d   = mode_q;
        div_d    = div_q;
        sut_d    = sut_q;
        divCnt_d = divCnt_q;
        tick_d   = 1'b0;
        fail_d   = fail_q;
        if (clearClockFail)
            fail_d = 1'b0;
        if (srst)
        begin
            src_d    = cfgSrc;
            mode_d   = cfgMode;
            div_d    = DIV_RESET;
            sut_d    = '0;
            divCnt_d = '0;
            fail_d   = 1'b0;
            state_d  = (cfgSrc == SRC_EXT && isCrystal(cfgMode)) ? ST_START : ST_RUN;
        end
        else if (failPulse)
        begin
            src_d    = SRC_FAST1;
            state_d  = ST_FAILSAFE;
            divCnt_d = '0;
            fail_d   = 1'b1;
        end
        else if (wakeFromSleep && src_q == SRC_EXT && isCrystal(mode_q))
        begin
            state_d = ST_START;
            sut_d   = '0;
        end
        else if (switchWrite)
        begin
            src_d    = legalSource(newSourceRequest);
            div_d    = (newDividerRequest > 4'(DIV_MAX)) ? 4'(DIV_MAX) : newDividerRequest;
            divCnt_d = '0;
            sut_d    = '0;
            state_d  = (legalSource(newSourceRequest) == SRC_EXT && isCrystal(mode_q))
                       ? ST_START : ST_RUN;
        end
        else
        begin
            case (state_q)
                ST_START:
                begin
                    // counts oscillations only; a silent crystal never releases
                    if (externalClockPin)
                    begin
                        sut_d = sut_q + OW'(1);
                        if (sut_q == OW'(SUT_COUNT - 1))
                            state_d = ST_RUN;
                    end
                end
                ST_RUN, ST_FAILSAFE:
                begin
                    // nothing moves between edges, so a stopped clock just pauses
                    if (selTick)
                    begin
                        if ((divCnt_q & divMask) == divMask)
                        begin
                            tick_d   = 1'b1;
                            divCnt_d = '0;
                        end
                        else
                            divCnt_d = divCnt_q + 9'h1;
                    end
                end
                default: state_d = ST_RUN;
            endcase
        end
        if (failPulse && !srst)
            fail_d = 1'b1;
        gain_d    = (src_d == SRC_EXT) ? gainOf(mode_d) : GAIN_OFF;
        pwr_d     = (src_d == SRC_EXT) ? powerOf(mode_d) : PWR_NONE;
        pinFree_d = (src_d == SRC_EXT) && !isCrystal(mode_d);
        fast32_d  = (src_d == SRC_FAST32);
    end

    always_ff @(posedge clock)
    begin
        state_q   <= state_d;
        src_q     <= src_d;
        mode_q    <= mode_d;
        div_q     <= div_d;
        sut_q     <= sut_d;
        divCnt_q  <= divCnt_d;
        tick_q    <= tick_d;
        fail_q    <= fail_d;
        gain_q    <= gain_d;
        pwr_q     <= pwr_d;
        pinFree_q <= pinFree_d;
        fast32_q  <= fast32_d;
    end

    assign sourceSelect  = src_q;
    assign dividerSelect = div_q;
    assign systemTick    = tick_q;
    assign amplifierGain = gain_q;
    assign extPowerRange = pwr_q;
    assign secondPinFree = pinFree_q;
    assign fast32Select  = fast32_q;
    assign startupBusy   = state_q[0];
    assign clockFail     = fail_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_source : assert property (@(posedge clock)
        srst |=> src_q == legalSource($past(resetClockSelect)))
        else $error("reset source not taken from config");

    a_fast32_flag : assert property (@(posedge clock) disable iff (srst)
        fast32Select == (sourceSelect == SRC_FAST32))
        else $error("32 MHz flag disagrees with source");

    a_gain_match : assert property (@(posedge clock) disable iff (srst)
        (sourceSelect == SRC_EXT && mode_q == XTAL_HI_GAIN) |-> amplifierGain == GAIN_HIGH)
        else $error("crystal gain wrong");

    a_pin_freed : assert property (@(posedge clock) disable iff (srst)
        (sourceSelect == SRC_EXT && !isCrystal(mode_q)) |-> secondPinFree && !startupBusy)
        else $error("logic clock mode pin or start-up wrong");

    a_no_startup_delay : assert property (@(posedge clock)
        (srst && cfgSrc == SRC_EXT && !isCrystal(cfgMode)) |=> state_q == ST_RUN)
        else $error("logic clock mode delayed by start-up");

    a_startup_release : assert property (@(posedge clock) disable iff (srst)
        (state_q == ST_START && externalClockPin && sut_q == OW'(SUT_COUNT - 1)
         && !failPulse && !wakeFromSleep && !switchWrite) |=> state_q == ST_RUN)
        else $error("start-up timer did not release");

    a_startup_hold : assert property (@(posedge clock) disable iff (srst)
        (state_q == ST_START && !externalClockPin && !switchWrite) |=> state_q == ST_START)
        else $error("start-up released without oscillation");

    a_static_hold : assert property (@(posedge clock) disable iff (srst)
        (src_q == SRC_EXT && !externalClockPin && !switchWrite && !failPulse)
        |=> !systemTick && $stable(divCnt_q))
        else $error("state moved without clock edge");

    a_fallback : assert property (@(posedge clock) disable iff (srst)
        failPulse |=> sourceSelect == SRC_FAST1 && clockFail)
        else $error("no fallback on failure");

    a_fail_wins : assert property (@(posedge clock) disable iff (srst)
        (failPulse && clearClockFail) |=> clockFail)
        else $error("failure lost to clear");

    a_switch_div : assert property (@(posedge clock) disable iff (srst)
        (switchWrite && !failPulse && !wakeFromSleep && newDividerRequest <= 4'(DIV_MAX))
        |=> dividerSelect == $past(newDividerRequest))
        else $error("divider request not applied");

    c_startup_done : cover property (@(posedge clock) disable iff (srst)
        state_q == ST_START ##1 state_q == ST_RUN);
    c_fallback : cover property (@(posedge clock) disable iff (srst) failPulse);
    c_switch : cover property (@(posedge clock) disable iff (srst)
        switchWrite ##1 systemTick);

endmodule
`default_nettype wire

// ===== bench/ccs_ext_osc_model.sv
// behavioural external clock or crystal that pulses the oscillator pin
`timescale 1ns/1ps
`default_nettype none
module ccs_ext_osc_model (
    // clock
    input  wire logic       clock,
    // control
    input  wire logic       run,
    input  wire logic [3:0] period,
    // pin side
    output var  logic       pinPulse,
    output var  logic [7:0] pulseCount
);
    logic [3:0] phase = 4'h0;

    initial pinPulse = 1'b0;
    initial pulseCount = 8'h00;

    // ----------------------------------------------------------------
    // edge generator
    // ----------------------------------------------------------------
    // a stopped source gives no edges at all, so the pin stays low
    always @(posedge clock)
    begin
        if (!run)
        begin
            phase      <= 4'h0;
            pinPulse   <= 1'b0;
            pulseCount <= 8'h00;
        end
        else
        begin
            phase      <= (phase + 4'h1 >= period) ? 4'h0 : phase + 4'h1;
            pinPulse   <= (phase == 4'h0);
            pulseCount <= pulseCount + ((phase == 4'h0) ? 8'h01 : 8'h00);
        end
    end
endmodule
`default_nettype wire

// ===== bench/ccs_source_select_tb_top.sv
// self-checking bench for the clock source selection block
`timescale 1ns/1ps
`default_nettype none
module ccs_source_select_tb_top;
    import ccs_pkg::*;

    // ----------------------------------------------------------------
    // types and signals
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic       full;
        logic [2:0] src;
        logic [3:0] div;
        logic [1:0] gain;
        logic [1:0] pwr;
        logic       free;
        logic       f32;
        logic       busy;
        logic       fail;
        logic [7:0] ticks;
    } ccs_exp_t;

    localparam int SUT_SIM  = 8;
    localparam int FAIL_SIM = 4;

    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] resetClockSelect = SRC_FAST32;
    logic [2:0] externalModeSelect = EXT_CLK_HIGH;
    logic       switchWrite = 1'b0;
    logic [2:0] newSourceRequest = SRC_FAST1;
    logic [3:0] newDividerRequest = 4'h0;
    logic       externalClockPin;
    logic       slowOscTick = 1'b0;
    logic       fastOscTick = 1'b0;
    logic       wakeFromSleep = 1'b0;
    logic       clearClockFail = 1'b0;
    logic [2:0] sourceSelect;
    logic [3:0] dividerSelect;
    logic       systemTick;
    logic [1:0] amplifierGain;
    logic [1:0] extPowerRange;
    logic       secondPinFree;
    logic       fast32Select;
    logic       startupBusy;
    logic       clockFail;
    logic       extRun = 1'b0;
    logic [7:0] pulseCount;
    logic [3:0] slowDiv = 4'h0;
    logic [7:0] tickCnt = 8'h00;
    logic       clrTicks = 1'b0;
    logic       checkReq = 1'b0;
    ccs_exp_t   expQ [$];
    ccs_exp_t   seen;
    int         n_fail = 0;
    int         num_checks = 0;
    int         seed;

    always #5 clock = ~clock;

    ccs_source_select #(
        .SUT_COUNT  (SUT_SIM),
        .FAIL_COUNT (FAIL_SIM)
    ) ccs_source_select_inst (
        .clock              (clock),
        .srst               (srst),
        .resetClockSelect   (resetClockSelect),
        .externalModeSelect (externalModeSelect),
        .switchWrite        (switchWrite),
        .newSourceRequest   (newSourceRequest),
        .newDividerRequest  (newDividerRequest),
        .externalClockPin   (externalClockPin),
        .slowOscTick        (slowOscTick),
        .fastOscTick        (fastOscTick),
        .wakeFromSleep      (wakeFromSleep),
        .clearClockFail     (clearClockFail),
        .sourceSelect       (sourceSelect),
        .dividerSelect      (dividerSelect),
        .systemTick         (systemTick),
        .amplifierGain      (amplifierGain),
        .extPowerRange      (extPowerRange),
        .secondPinFree      (secondPinFree),
        .fast32Select       (fast32Select),
        .startupBusy        (startupBusy),
        .clockFail          (clockFail)
    );

    ccs_ext_osc_model ccs_ext_osc_model_inst (
        .clock      (clock),
        .run        (extRun),
        .period     (4'h4),
        .pinPulse   (externalClockPin),
        .pulseCount (pulseCount)
    );

    // ----------------------------------------------------------------
    // oscillator ticks and result monitor
    // ----------------------------------------------------------------
    // fast oscillator every cycle, slow one every 16 cycles
    always @(posedge clock)
    begin
        fastOscTick <= 1'b1;
        slowDiv     <= slowDiv + 4'h1;
        slowOscTick <= (slowDiv == 4'hF);
        tickCnt     <= clrTicks ? 8'h00 : tickCnt + {7'h00, systemTick};
    end

    always @(negedge clock)
    begin
        if (checkReq)
        begin
            seen = expQ.pop_front();
            num_checks++;
            if (sourceSelect !== seen.src || dividerSelect !== seen.div
                || fast32Select !== seen.f32 || clockFail !== seen.fail
                || (seen.full && {amplifierGain, extPowerRange, secondPinFree, startupBusy}
                    !== {seen.gain, seen.pwr, seen.free, seen.busy})
                || (seen.ticks != 8'hFF && tickCnt !== seen.ticks))
            begin
                n_fail++;
                $display("CHECK FAILED at %0t: outputs differ from expected %h", $time, seen);
            end
        end
    end

    // ----------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic expect_now(input ccs_exp_t e);
        @(posedge clock);
        expQ.push_back(e);
        checkReq <= 1'b1;
        @(posedge clock);
        checkReq <= 1'b0;
    endtask

    // window of n sampled cycles ends at the next expect_now
    task automatic tick_window(input int n);
        @(posedge clock);
        clrTicks <= 1'b1;
        @(posedge clock);
        clrTicks <= 1'b0;
        cyc(n - 1);
    endtask

    task automatic do_reset(input logic [2:0] sel, input logic [2:0] mode);
        @(posedge clock);
        srst               <= 1'b1;
        extRun             <= 1'b0;
        resetClockSelect   <= sel;
        externalModeSelect <= mode;
        cyc(4);
        srst   <= 1'b0;
        extRun <= 1'b1;
    endtask

    task automatic write_req(input logic [2:0] src, input logic [3:0] div);
        @(posedge clock);
        switchWrite       <= 1'b1;
        newSourceRequest  <= src;
        newDividerRequest <= div;
        @(posedge clock);
        switchWrite <= 1'b0;
    endtask

    task automatic wake_pulse();
        wakeFromSleep <= 1'b1;
        @(posedge clock);
        wakeFromSleep <= 1'b0;
    endtask

    function automatic ccs_exp_t reset_exp(input logic [2:0] sel, input logic [2:0] mode);
        ccs_exp_t e;
        logic     xtal;
        xtal    = mode inside {XTAL_LOW_PWR, XTAL_MED_GAIN, XTAL_HI_GAIN};
        e       = '0;
        e.ticks = 8'hFF;
        e.full  = (sel == SRC_EXT);
        e.src   = (sel inside {SRC_FAST32, SRC_SLOW, SRC_FAST1, SRC_EXT}) ? sel : SRC_FAST1;
        e.f32   = (sel == SRC_FAST32);
        e.gain  = (mode == XTAL_LOW_PWR) ? GAIN_LOW : (mode == XTAL_MED_GAIN) ? GAIN_MED
                : (mode == XTAL_HI_GAIN) ? GAIN_HIGH : GAIN_OFF;
        e.pwr   = xtal ? PWR_NONE : (mode == EXT_CLK_MED) ? PWR_MED
                : (mode == EXT_CLK_LOW) ? PWR_LOW : PWR_HIGH;
        e.free  = !xtal;
        e.busy  = xtal;
        return e;
    endfunction

    function automatic ccs_exp_t sw_exp(input logic [2:0] s, input logic [3:0] d,
                                        input logic f, input logic [7:0] t);
        ccs_exp_t e;
        e       = reset_exp(s, EXT_CLK_HIGH);
        e.full  = 1'b0;
        e.div   = d;
        e.fail  = f;
        e.ticks = t;
        return e;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        ccs_exp_t   e;
        logic [3:0] d;
        logic [2:0] selList [5];
        selList = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h3};
        seed = 5850;
        foreach (selList[i])
        begin
            do_reset(selList[i], EXT_CLK_HIGH);
            expect_now(reset_exp(selList[i], EXT_CLK_HIGH));
        end
        // every mode code, reserved ones included; crystals time the start-up
        for (int m = 0; m < 8; m++)
        begin
            e = reset_exp(SRC_EXT, 3'(m));
            do_reset(SRC_EXT, 3'(m));
            if (e.busy)
            begin
                cyc(28);
                @(negedge clock);
                num_checks++;
                // last counted oscillation still in flight here
                if (pulseCount !== 8'(SUT_SIM - 1))
                begin
                    n_fail++;
                    $display("CHECK FAILED at %0t: start-up pulse count %0d", $time, pulseCount);
                end
                expect_now(e);
                e.busy = 1'b0;
                cyc(2);
                expect_now(e);
                // wake from sleep restarts the whole start-up count
                wake_pulse();
                e.busy = 1'b1;
                cyc(29);
                expect_now(e);
                e.busy = 1'b0;
                cyc(2);
            end
            else
                wake_pulse();
            expect_now(e);
        end
        // logic clock: ticks follow pin edges, stop with them, then fallback
        do_reset(SRC_EXT, EXT_CLK_HIGH);
        e = reset_exp(SRC_EXT, EXT_CLK_HIGH);
        tick_window(16);
        e.ticks = 8'h04;
        expect_now(e);
        @(posedge clock);
        extRun <= 1'b0;
        tick_window(12);
        e.ticks = 8'h00;
        expect_now(e);
        cyc(30);
        expect_now(e);
        cyc(22);
        expect_now(sw_exp(SRC_FAST1, 4'h0, 1'b1, 8'hFF));
        @(posedge clock);
        clearClockFail <= 1'b1;
        @(posedge clock);
        clearClockFail <= 1'b0;
        expect_now(sw_exp(SRC_FAST1, 4'h0, 1'b0, 8'hFF));
        // run-time switching, divider and clamping
        do_reset(SRC_FAST32, EXT_CLK_HIGH);
        write_req(SRC_FAST1, 4'h2);
        tick_window(16);
        expect_now(sw_exp(SRC_FAST1, 4'h2, 1'b0, 8'h04));
        write_req(3'h3, 4'hF);
        expect_now(sw_exp(SRC_FAST1, 4'h9, 1'b0, 8'hFF));
        write_req(SRC_SLOW, 4'h0);
        tick_window(32);
        expect_now(sw_exp(SRC_SLOW, 4'h0, 1'b0, 8'h02));
        // back to back: the later write wins
        @(posedge clock);
        switchWrite       <= 1'b1;
        newSourceRequest  <= SRC_FAST1;
        newDividerRequest <= 4'h1;
        @(posedge clock);
        newSourceRequest <= SRC_EXT;
        @(posedge clock);
        switchWrite <= 1'b0;
        tick_window(32);
        expect_now(sw_exp(SRC_EXT, 4'h1, 1'b0, 8'h04));
        for (int k = 0; k < 4; k++)
        begin
            d = 4'($random(seed));
            write_req(SRC_FAST1, d);
            expect_now(sw_exp(SRC_FAST1, (d > 4'h9) ? 4'h9 : d, 1'b0, 8'hFF));
        end
        cyc(2);
        tally_and_finish();
    end

    initial
    begin
        #50000;
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish in time", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
